// *** rtl/ssc_defs.svh ***
// register offsets, field positions and reset values of the stream sample capture unit
`ifndef SSC_DEFS_SVH
`define SSC_DEFS_SVH
`define SSC_OFS_CTRL 8'h00
`define SSC_OFS_IER 8'h04
`define SSC_OFS_ISR 8'h08
`define SSC_OFS_FAIL 8'h0C
`define SSC_OFS_CGCTL 8'h10
`define SSC_OFS_FMT 8'h14
`define SSC_OFS_DATA 8'h20
`define SSC_CTRL_RST 32'h0000_0000
`define SSC_CTRL_WMASK 32'h0F0F_CF21
`define SSC_CTRL_AF_LSB 24
`define SSC_CTRL_AE_LSB 16
`define SSC_CTRL_NAV_GATE 15
`define SSC_CTRL_TS_GATE 14
`define SSC_CTRL_NAV_W4 11
`define SSC_CTRL_SYNC_EN 10
`define SSC_CTRL_VALID_EN 9
`define SSC_CTRL_SRC_SEL 8
`define SSC_CTRL_DMA_MODE 5
`define SSC_CTRL_EN 0
`define SSC_IER_RST 2'h0
`define SSC_ISR_RST 2'h0
`define SSC_ISR_FULL 0
`define SSC_ISR_EMPTY 1
`define SSC_CG_RST 32'h0000_0000
`define SSC_FMT_RST 5'h00
`define SSC_AF_BASE 8'h40
`define SSC_BITS_TS 4'h8
`define SSC_BITS_NAV4 4'h4
`define SSC_BITS_NAV2 4'h2
`endif

// *** rtl/ssc_pkg.sv ***
// types shared by the stream sample capture unit
package ssc_pkg;
  // pad group as seen after the synchroniser
  typedef struct packed {
    logic clk;
    logic [7:0] data;
    logic frame;
    logic qual;
    logic err;
  } ssc_pad_t;
  // sample format controls
  typedef struct packed {
    logic ten;
    logic high;
    logic sext;
    logic inv;
    logic dual;
  } ssc_fmt_t;
  // frame alignment state of the stream input
  typedef enum logic {
    SSC_HUNT = 1'b0,
    SSC_LOCK = 1'b1
  } ssc_align_t;
endpackage

// *** rtl/ssc_fifo.sv ***
// capture fifo, one word per entry, fill level exported for watermarks
`timescale 1ns/10ps
module ssc_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 128,
  parameter int AW = 7
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // write side
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WIDTH-1:0] wr_data,
  // read side
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [WIDTH-1:0] rd_data,
  output logic [AW:0] level
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wptr_q, wptr_d, rptr_q, rptr_d;
  logic full;

  // full when pointers differ only in the wrap bit
  assign full = (wptr_q[AW] != rptr_q[AW]) && (wptr_q[AW-1:0] == rptr_q[AW-1:0]);
  assign wr_ready = !full;
  assign rd_valid = (wptr_q != rptr_q);
  assign level = wptr_q - rptr_q;
  assign rd_data = mem[rptr_q[AW-1:0]];

  // pointer advance
  always_comb begin
    wptr_d = wptr_q;
    rptr_d = rptr_q;
    if (wr_valid && wr_ready) begin
      wptr_d = wptr_q + 1'b1;
    end
    if (rd_ready && rd_valid) begin
      rptr_d = rptr_q + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wptr_q <= '0;
      rptr_q <= '0;
    end else begin
      wptr_q <= wptr_d;
      rptr_q <= rptr_d;
    end
  end

  // storage has no reset; an empty fifo is never read
  always_ff @(posedge sys_clk) begin
    if (wr_valid && wr_ready) begin
      mem[wptr_q[AW-1:0]] <= wr_data;
    end
  end

  fifo_bound_a: assert property (@(posedge sys_clk) disable iff (reset) // R10
    (level == (AW+1)'(DEPTH)) |=> (level == (AW+1)'(DEPTH)) || $fell(full))
    else $error("fifo level left full without a read");
endmodule // ssc_fifo

// *** rtl/ssc_pack.sv ***
// widens captured samples into halfwords and packs four into a fifo word
`timescale 1ns/10ps
module ssc_pack
  import ssc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // sample side
  input wire logic clear,
  input wire logic in_valid,
  input wire logic [7:0] in_sample,
  input wire logic [3:0] in_bits,
  input wire ssc_fmt_t fmt,
  // word side
  output logic out_valid,
  output logic [63:0] out_word
);
  logic [63:0] buf_q, buf_d, word_q, word_d;
  logic [1:0] cnt_q, cnt_d;
  logic vld_q, vld_d;
  logic [15:0] h0, h1, hs;
  logic [3:0] half;

  // msb negation, sign extension and high/low placement of one sample
  function automatic logic [15:0] widen(input logic [7:0] v, input logic [3:0] n,
                                        input ssc_fmt_t f);
    logic [15:0] x;
    logic s;
    logic [4:0] w;
    x = 16'h0000;
    w = f.ten ? 5'h0A : 5'h08;
    for (int i = 0; i < 8; i++) begin
      if (i < n) x[i] = v[i];
    end
    x[n - 4'h1] = x[n - 4'h1] ^ f.inv; // R7
    s = x[n - 4'h1];
    if (f.high) begin
      x = x << (5'h10 - {1'b0, n}); // R9
    end else begin
      for (int i = 0; i < 16; i++) begin
        if (i >= n && i < w && f.sext) x[i] = s; // R8
      end
    end
    return x;
  endfunction

  // dual channel splits each sample into two halves
  assign half = in_bits >> 1;
  assign hs = widen(in_sample, in_bits, fmt);
  assign h0 = widen(in_sample, half, fmt);
  assign h1 = widen(in_sample >> half, half, fmt);
  assign out_valid = vld_q;
  assign out_word = word_q;

  // accumulate halfwords, oldest in the low lane
  always_comb begin
    buf_d = buf_q;
    cnt_d = cnt_q;
    vld_d = 1'b0;
    word_d = word_q;
    if (clear) begin
      cnt_d = 2'h0;
    end else if (in_valid) begin
      if (fmt.dual) begin // R6
        buf_d[{cnt_q[1], 5'h00} +: 32] = {h1, h0};
        cnt_d = {~cnt_q[1], 1'b0};
        vld_d = cnt_q[1];
      end else begin
        buf_d[{cnt_q, 4'h0} +: 16] = hs;
        cnt_d = cnt_q + 2'h1;
        vld_d = (cnt_q == 2'h3);
      end
      if (vld_d) begin
        word_d = buf_d;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      buf_q <= 64'h0;
      cnt_q <= 2'h0;
      vld_q <= 1'b0;
      word_q <= 64'h0;
    end else begin
      buf_q <= buf_d;
      cnt_q <= cnt_d;
      vld_q <= vld_d;
      word_q <= word_d;
    end
  end
endmodule // ssc_pack

// *** rtl/ssc_top.sv ***
// stream sample capture unit: pad sampling, packing, fifo, dma request and registers
// Functional notes
// (R1) Capture words into the fifo only on sampling clock edges while enabled.
// (R2) Raise the dma request from the almost-full or almost-empty watermark.
// (R3) Stream mode takes eight data bits per sampling edge from the source.
// (R4) Navigation mode takes two-bit or four-bit samples.
// (R5) One interrupt output combines fifo full and fifo empty.
// (R6) Single-channel and dual-channel sample capture are both supported.
// (R7) The sample msb may be inverted before storing.
// (R8) Samples may be sign-extended when widened to a halfword.
// (R9) Samples sit in the upper or lower part of a halfword.
// (R10) One fifo of 128 words by 64 bits holds captured data.
// (R11) Almost-full level at bits 27:24, 64 plus four entries per step.
// (R12) Almost-empty level at bits 19:16, four entries per step.
// (R13) Bit 15 lets the timed clock gate stop the navigation input.
// (R14) Bit 14 lets the timed clock gate stop the stream input.
// (R15) Bit 11 selects two-bit (0) or four-bit (1) navigation samples.
// (R16) Bit 10 enables frame-marker alignment of stream bytes.
// (R17) Bit 9 makes the byte qualifier gate stream bytes; otherwise ignored.
// (R18) Input select: one takes the stream input, zero the navigation input.
// (R19) Source drives data, frame marker, qualifier, error and sampling clock.
// (R20) Navigation capture runs on edges of the receiver's pad clock.
// (R21) Bit 5: hold request from almost-full to almost-empty, else one pulse.
// (R22) Enable bit reads one once transfer started; other fields locked then.
// (R23) Full and empty flags set by hardware, cleared by writing zero.
// (R24) Decode fail indicator reads one on stream failure, only with stream input.
// (R25) Reading the data register returns the oldest word and pops it; here two reads give the low then the high half, and the second read pops.
// (R26) Interrupt output is any status flag set together with its enable.
`timescale 1ns/10ps
`include "ssc_defs.svh"
module ssc_top
  import ssc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // ahb register slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // capture pads, asynchronous to sys_clk
  input wire ssc_pad_t pad_in,
  // system side
  output logic dma_req,
  output logic irq
);
  ssc_pad_t sync1_q, sync2_q;
  logic clk_prev_q, edge_seen;
  logic [31:0] ctrl_q, ctrl_d, cg_q, cg_d, rdata_q, rdata_d;
  logic [1:0] ier_q, ier_d, stat_q, stat_d;
  ssc_fmt_t fmt_q, fmt_d;
  logic [30:0] gate_cnt_q, gate_cnt_d;
  ssc_align_t align_q, align_d;
  logic fail_q, fail_d, started_q, started_d, req_q, req_d, above_q, above_d;
  logic half_q, half_d, wpend_q, wpend_d;
  logic [7:0] waddr_q, waddr_d;
  logic addr_phase, rd_data_reg, pop;
  logic en, src_ts, gated, accept, pk_valid, push, fifo_ready, fifo_valid;
  logic [7:0] sample, level, af_th, ae_th;
  logic [3:0] nbits;
  logic [63:0] pk_word, fifo_word;

  // two-stage synchroniser for the whole pad group
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sync1_q <= '0;
      sync2_q <= '0;
      clk_prev_q <= 1'b0;
    end else begin
      sync1_q <= pad_in;
      sync2_q <= sync1_q;
      clk_prev_q <= sync2_q.clk;
    end
  end

  // rising edge of the pad clock; data sampled with it is two cycles old
  assign edge_seen = sync2_q.clk && !clk_prev_q; // R20
  assign en = ctrl_q[`SSC_CTRL_EN];
  assign src_ts = ctrl_q[`SSC_CTRL_SRC_SEL]; // R18
  // timed gate stops only the input whose auto-gate bit is set
  assign gated = (gate_cnt_q != 31'h0) &&
                 (src_ts ? ctrl_q[`SSC_CTRL_TS_GATE] : ctrl_q[`SSC_CTRL_NAV_GATE]); // R13 R14

  // sample selection and qualification per input
  always_comb begin
    sample = sync2_q.data; // R3
    nbits = `SSC_BITS_TS;
    accept = 1'b1;
    if (src_ts) begin
      if (ctrl_q[`SSC_CTRL_VALID_EN] && !sync2_q.qual) begin
        accept = 1'b0; // R17
      end
      if (ctrl_q[`SSC_CTRL_SYNC_EN] && align_q == SSC_HUNT && !sync2_q.frame) begin
        accept = 1'b0; // R16
      end
    end else if (ctrl_q[`SSC_CTRL_NAV_W4]) begin
      sample = {4'h0, sync2_q.data[3:0]}; // R4 R15
      nbits = `SSC_BITS_NAV4;
    end else begin
      sample = {6'h00, sync2_q.data[1:0]}; // R15
      nbits = `SSC_BITS_NAV2;
    end
  end

  ssc_pack u_pack (
    .sys_clk(sys_clk),
    .reset(reset),
    .clear(!en),
    .in_valid(en && edge_seen && accept && !gated), // R1
    .in_sample(sample),
    .in_bits(nbits),
    .fmt(fmt_q),
    .out_valid(pk_valid),
    .out_word(pk_word)
  );

  // words arriving at a full fifo are dropped; the watermark dma must keep up
  assign push = pk_valid && en;

  ssc_fifo #(
    .WIDTH(64),
    .DEPTH(128),
    .AW(7)
  ) u_fifo (
    .sys_clk(sys_clk),
    .reset(reset),
    .wr_valid(push), // R10
    .wr_ready(fifo_ready),
    .wr_data(pk_word),
    .rd_valid(fifo_valid),
    .rd_ready(pop),
    .rd_data(fifo_word),
    .level(level)
  );

  // watermark thresholds in fifo entries
  assign af_th = `SSC_AF_BASE + {2'h0, ctrl_q[`SSC_CTRL_AF_LSB +: 4], 2'h0}; // R11
  assign ae_th = {2'h0, ctrl_q[`SSC_CTRL_AE_LSB +: 4], 2'h0}; // R12

  // frame alignment, fail capture, start tracking and dma request
  always_comb begin
    align_d = align_q;
    fail_d = fail_q;
    started_d = started_q || push;
    above_d = level > ae_th;
    req_d = 1'b0;
    if (!en) begin
      align_d = SSC_HUNT;
      started_d = 1'b0;
    end else if (edge_seen && src_ts && !gated && sync2_q.frame) begin
      align_d = SSC_LOCK;
    end
    if (wpend_q && waddr_q == `SSC_OFS_FAIL && !hwdata[0]) begin
      fail_d = 1'b0;
    end
    if (edge_seen && src_ts && sync2_q.err) begin
      fail_d = 1'b1; // R24
    end
    if (en && ctrl_q[`SSC_CTRL_DMA_MODE]) begin
      req_d = req_q ? (level > ae_th) : (level > af_th); // R2 R21
    end else if (en) begin
      req_d = above_d && !above_q; // R21
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      align_q <= SSC_HUNT;
      fail_q <= 1'b0;
      started_q <= 1'b0;
      above_q <= 1'b0;
      req_q <= 1'b0;
    end else begin
      align_q <= align_d;
      fail_q <= fail_d;
      started_q <= started_d;
      above_q <= above_d;
      req_q <= req_d;
    end
  end

  assign dma_req = req_q;
  assign irq = |(stat_q & ier_q); // R5 R26
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;

  // ahb address phase; reads are answered from a register in the data phase
  assign addr_phase = hsel && hready && htrans[1];
  assign rd_data_reg = addr_phase && !hwrite && haddr == `SSC_OFS_DATA;
  assign pop = rd_data_reg && half_q && fifo_valid; // R25

  // register file next state
  always_comb begin
    ctrl_d = ctrl_q;
    ier_d = ier_q;
    stat_d = stat_q;
    cg_d = cg_q;
    fmt_d = fmt_q;
    half_d = half_q;
    wpend_d = addr_phase && hwrite;
    waddr_d = addr_phase ? haddr : waddr_q;
    rdata_d = rdata_q;
    gate_cnt_d = (gate_cnt_q != 31'h0) ? gate_cnt_q - 31'h1 : 31'h0;
    if (wpend_q) begin
      if (waddr_q == `SSC_OFS_CTRL) begin
        if (en && started_q) begin
          ctrl_d[`SSC_CTRL_EN] = hwdata[`SSC_CTRL_EN]; // R22
        end else begin
          ctrl_d = hwdata & `SSC_CTRL_WMASK;
        end
      end else if (waddr_q == `SSC_OFS_IER) begin
        ier_d = hwdata[1:0];
      end else if (waddr_q == `SSC_OFS_ISR) begin
        stat_d = stat_q & hwdata[1:0]; // R23
      end else if (waddr_q == `SSC_OFS_CGCTL) begin
        cg_d = hwdata;
        if (hwdata[0] && hwdata[31:1] != 31'h0) begin
          gate_cnt_d = hwdata[31:1];
        end
      end else if (waddr_q == `SSC_OFS_FMT) begin
        fmt_d = ssc_fmt_t'(hwdata[4:0]);
      end
    end
    // a flag raised in the clearing cycle stays set
    stat_d[`SSC_ISR_FULL] = stat_d[`SSC_ISR_FULL] || !fifo_ready; // R23
    stat_d[`SSC_ISR_EMPTY] = stat_d[`SSC_ISR_EMPTY] || !fifo_valid; // R23
    if (!en) begin
      half_d = 1'b0;
    end
    if (addr_phase && !hwrite) begin
      if (haddr == `SSC_OFS_CTRL) begin
        rdata_d = {ctrl_q[31:1], en && started_q}; // R22
      end else if (haddr == `SSC_OFS_IER) begin
        rdata_d = {30'h0, ier_q};
      end else if (haddr == `SSC_OFS_ISR) begin
        rdata_d = {30'h0, stat_q};
      end else if (haddr == `SSC_OFS_FAIL) begin
        rdata_d = {31'h0, fail_q && src_ts}; // R24
      end else if (haddr == `SSC_OFS_CGCTL) begin
        rdata_d = cg_q;
      end else if (haddr == `SSC_OFS_FMT) begin
        rdata_d = {27'h0, fmt_q};
      end else if (haddr == `SSC_OFS_DATA) begin
        rdata_d = fifo_valid ? (half_q ? fifo_word[63:32] : fifo_word[31:0]) : 32'h0;
        half_d = fifo_valid ? !half_q : half_q; // R25
      end else begin
        rdata_d = 32'h0;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ctrl_q <= `SSC_CTRL_RST;
      ier_q <= `SSC_IER_RST;
      stat_q <= `SSC_ISR_RST;
      cg_q <= `SSC_CG_RST;
      fmt_q <= ssc_fmt_t'(`SSC_FMT_RST);
      half_q <= 1'b0;
      wpend_q <= 1'b0;
      waddr_q <= 8'h00;
      rdata_q <= 32'h0;
      gate_cnt_q <= 31'h0;
    end else begin
      ctrl_q <= ctrl_d;
      ier_q <= ier_d;
      stat_q <= stat_d;
      cg_q <= cg_d;
      fmt_q <= fmt_d;
      half_q <= half_d;
      wpend_q <= wpend_d;
      waddr_q <= waddr_d;
      rdata_q <= rdata_d;
      gate_cnt_q <= gate_cnt_d;
    end
  end

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  no_push_idle_a: assert property (!en && !$past(en) |-> !pk_valid) // R1
    else $error("packer produced a word while unit disabled");
  dma_rise_a: assert property ( // R2
    en && ctrl_q[`SSC_CTRL_DMA_MODE] && !req_q && level > af_th ##1 en |-> req_q)
    else $error("dma request missed almost-full level");
  dma_hold_a: assert property ( // R21
    req_q && en && ctrl_q[`SSC_CTRL_DMA_MODE] && level > ae_th ##1 en |-> req_q)
    else $error("dma request dropped above almost-empty level");
  dma_pulse_a: assert property ( // R21
    req_q && !ctrl_q[`SSC_CTRL_DMA_MODE] && $stable(ctrl_q) |=> !req_q)
    else $error("single dma request longer than one cycle");
  full_flag_a: assert property (!fifo_ready |=> stat_q[`SSC_ISR_FULL]) // R23
    else $error("full flag not set on full fifo");
  irq_full_a: assert property ( // R26
    !fifo_ready && ier_q[`SSC_ISR_FULL] && $stable(ier_q) ##1 $stable(ier_q) |-> irq)
    else $error("interrupt missing for enabled full flag");
  flag_clear_a: assert property ( // R23
    wpend_q && waddr_q == `SSC_OFS_ISR && !hwdata[0] && fifo_ready |=> !stat_q[0])
    else $error("full flag not cleared by writing zero");
  pop_level_a: assert property (pop && !push |=> level == $past(level) - 8'h01) // R25
    else $error("data read did not pop the fifo");
  ctrl_lock_a: assert property ( // R22
    wpend_q && waddr_q == `SSC_OFS_CTRL && en && started_q |=>
    ctrl_q[31:1] == $past(ctrl_q[31:1]))
    else $error("control field changed while transfer running");
  fail_sel_a: assert property (!src_ts |=> rdata_q[0] == 1'b0 || $past(haddr) != `SSC_OFS_FAIL ||
    $past(hwrite) || !$past(addr_phase) || $past(src_ts)) // R24
    else $error("fail indicator seen with navigation input");

  cov_lock_c: cover property (align_q == SSC_HUNT ##1 align_q == SSC_LOCK);
  cov_full_c: cover property (!fifo_ready);
  cov_dma_c: cover property (ctrl_q[`SSC_CTRL_DMA_MODE] && $rose(req_q));
  cov_pop_c: cover property (pop);
endmodule // ssc_top

// *** test/ssc_src_model.sv ***
// stream source and navigation front end model driving the capture pads
`timescale 1ns/10ps
module ssc_src_model
  import ssc_pkg::*;
(
  // pad group toward the capture unit
  output ssc_pad_t pad
);
  // pad clock stands still low outside samples
  initial begin
    pad = '0;
  end

  // one sampling edge of a 125 ns pad clock
  task automatic send(input logic [7:0] d, input logic fr, input logic q, input logic e);
    begin
      pad.data = d;
      pad.frame = fr;
      pad.qual = q;
      pad.err = e;
      #31.25;
      pad.clk = 1'b1;
      #62.5;
      pad.clk = 1'b0;
      // hold time over: inverse levels so a late sample cannot pass
      pad.data = ~d;
      pad.frame = ~fr;
      pad.qual = ~q;
      pad.err = ~e;
      #31.25;
    end
  endtask
endmodule // ssc_src_model

// *** test/stream_adc_capture_interface_tb.sv ***
// self-checking bench for the stream sample capture unit
`timescale 1ns/10ps
module stream_adc_capture_interface_tb
  import ssc_pkg::*;
;
  logic sys_clk;
  logic reset;
  logic hsel, hwrite, hready, rd_ph;
  logic [1:0] htrans;
  logic [7:0] haddr;
  logic [31:0] hwdata, hrdata;
  logic hreadyout, hresp, dma_req, irq;
  wire ssc_pad_t pad;
  int mismatches = 0;
  int checks = 0;
  int cyc = 0;
  int dma_n = 0;
  int i;
  int seed = 32'h9A57A7BE;
  logic [31:0] eq[$];
  string nq[$];
  logic [63:0] wq[$];
  logic [63:0] w;
  // capture cases: control, format, sample mask, error strobe
  logic [31:0] cc [9] = '{32'h101, 32'h101, 32'h801, 32'h101, 32'h301, 32'h501, 32'h101,
    32'h801, 32'h001};
  logic [4:0] ff [9] = '{5'h00, 5'h02, 5'h04, 5'h08, 5'h00, 5'h00, 5'h01, 5'h00, 5'h16};
  logic [7:0] mm [9] = '{8'hFF, 8'hFF, 8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'h03};
  logic ee [9] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
  logic [7:0] ofs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h20};
  logic [31:0] rst [7] = '{32'h0, 32'h0, 32'h2, 32'h0, 32'h0, 32'h0, 32'h0};

  ssc_top dut_u (.sys_clk(sys_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pad_in(pad), .dma_req(dma_req), .irq(irq));
  ssc_src_model src_u (.pad(pad));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    begin
      checks++;
      if (s !== e) begin
        mismatches++;
        $display("[ERR] %s expected %h seen %h", n, e, s);
      end
    end
  endtask

  task automatic complete_run;
    begin
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
        $display("TB: PASS");
      end else begin
        $display("TB: FAIL");
      end
      $finish;
    end
  endtask

  // one transfer: address phase, then data phase carrying write data
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
    begin
      @(posedge sys_clk);
      #1;
      hsel = 1'b1;
      htrans = 2'h2;
      hwrite = wr;
      haddr = a;
      @(posedge sys_clk);
      #1;
      hsel = 1'b0;
      htrans = 2'h0;
      hwdata = d;
    end
  endtask

  // write, then let the register update land
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    begin
      bus(a, 1'b1, d);
      @(posedge sys_clk);
      #1;
    end
  endtask

  // read: the expectation is noted, the watcher compares in the data phase
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] e, input string n);
    begin
      eq.push_back(e);
      nq.push_back(n);
      bus(a, 1'b0, 32'h0);
      rd_ph = 1'b1;
      @(negedge sys_clk);
      #1;
      rd_ph = 1'b0;
    end
  endtask

  // oldest note against the read data of each data phase
  always @(negedge sys_clk) begin
    if (rd_ph === 1'b1) check(nq.pop_front(), hrdata, eq.pop_front());
  end

  // dma request cycles, used to see a single pulse
  always @(posedge sys_clk) begin
    if (dma_req === 1'b1) dma_n++;
  end

  // cuts a hang short; the whole run needs well under this
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 40000) begin
      mismatches++;
      $display("[ERR] timeout");
      complete_run();
    end
  end

  // expected halfword of an n-bit sample; sign extension fills the 8- or 10-bit field
  function automatic logic [15:0] hw(input logic [7:0] v, input logic [4:0] f, input int n);
    logic [15:0] x;
    begin
      x = {8'h00, v};
      x[n-1] = x[n-1] ^ f[1];
      if (f[3]) return 16'(x << (16 - n));
      for (int j = n; j < (f[4] ? 10 : 8); j++) x[j] = f[2] & x[n-1];
      return x;
    end
  endfunction

  task automatic setup(input logic [31:0] c, input logic [4:0] f);
    begin
      reg_wr(8'h00, 32'h0);
      reg_wr(8'h14, {27'h0, f});
      reg_wr(8'h00, c);
    end
  endtask

  // sends one fifo word worth of samples and notes the expected word in w
  task automatic fill(input logic [31:0] c, input logic [4:0] f, input logic [7:0] m,
    input logic e);
    logic [7:0] b;
    int k;
    int n;
    begin
      k = 0;
      n = (m == 8'hFF) ? 8 : ((m == 8'h0F) ? 4 : 2);
      // a byte that must be dropped: unqualified and ahead of the frame marker
      if (c[9] | c[10]) src_u.send(8'h5A, 1'b0, 1'b0, 1'b0);
      while (k < 4) begin
        b = 8'($random(seed));
        src_u.send(b, k == 0, c[9], e && k == 0);
        b = b & m;
        if (f[0]) begin
          w[16*k +: 16] = {12'h000, b[3:0]};
          w[16*k+16 +: 16] = {12'h000, b[7:4]};
          k = k + 2;
        end else begin
          w[16*k +: 16] = hw(b, f, n);
          k = k + 1;
        end
      end
    end
  endtask

  task automatic drain(input int n);
    logic [63:0] x;
    begin
      repeat (n) begin
        x = wq.pop_front();
        reg_rd(8'h20, x[31:0], "drain low");
        reg_rd(8'h20, x[63:32], "drain high");
      end
    end
  endtask

  initial begin
    reset = 1'b1;
    hsel = 1'b0;
    hwrite = 1'b0;
    hready = 1'b1;
    htrans = 2'h0;
    haddr = 8'h00;
    hwdata = 32'h0;
    rd_ph = 1'b0;
    repeat (12) @(posedge sys_clk);
    #1;
    reset = 1'b0;
    for (i = 0; i < 7; i++) reg_rd(ofs[i], rst[i], "reset value");
    check("hresp", {31'h0, hresp}, 32'h0);
    check("hreadyout", {31'h0, hreadyout}, 32'h1);
    // empty source raises the combined output only while enabled
    reg_wr(8'h04, 32'h2);
    check("irq empty", {31'h0, irq}, 32'h1);
    reg_wr(8'h08, 32'h0);
    reg_rd(8'h08, 32'h2, "empty kept");
    reg_wr(8'h04, 32'h1);
    check("irq masked", {31'h0, irq}, 32'h0);
    // every capture mode, one word each
    for (i = 0; i < 9; i++) begin
      setup(cc[i], ff[i]);
      fill(cc[i], ff[i], mm[i], ee[i]);
      repeat (12) @(posedge sys_clk);
      reg_rd(8'h20, w[31:0], "data low");
      reg_rd(8'h20, w[63:32], "data high");
      reg_rd(8'h00, cc[i], "ctrl");
      reg_rd(8'h0C, {31'h0, ee[i] & cc[i][8]}, "fail");
      reg_wr(8'h0C, 32'h0);
      reg_rd(8'h0C, 32'h0, "fail cleared");
    end
    // fields are frozen while running; reserved bits read zero
    reg_wr(8'h00, 32'h0F00_0901);
    reg_rd(8'h00, 32'h0000_0001, "ctrl locked");
    reg_wr(8'h00, 32'h0);
    reg_wr(8'h00, 32'hFFFF_FFFE);
    reg_rd(8'h00, 32'h0F0F_CF20, "ctrl fields");
    reg_wr(8'h10, 32'h0000_0F00);
    reg_rd(8'h10, 32'h0000_0F00, "gate count");
    reg_wr(8'h30, 32'hFFFF_FFFF);
    reg_rd(8'h30, 32'h0, "unmapped");
    // a running timed gate swallows stream samples; capture resumes once it ends
    setup(32'h0000_4101, 5'h00);
    reg_wr(8'h10, 32'h0000_0201);
    fill(32'h0000_4101, 5'h00, 8'hFF, 1'b0);
    repeat (250) @(posedge sys_clk);
    fill(32'h0000_4101, 5'h00, 8'hFF, 1'b0);
    repeat (12) @(posedge sys_clk);
    reg_rd(8'h20, w[31:0], "gated low");
    reg_rd(8'h20, w[63:32], "gated high");
    // single pulse once the level passes four entries
    setup(32'h0001_0101, 5'h00);
    dma_n = 0;
    for (i = 0; i < 5; i++) begin
      fill(32'h0001_0101, 5'h00, 8'hFF, 1'b0);
      wq.push_back(w);
      repeat (12) @(posedge sys_clk);
      check("dma pulses", 32'(dma_n), (i == 4) ? 32'h1 : 32'h0);
    end
    drain(5);
    // held request from above 64 entries down to four, overfilled fifo
    setup(32'h0001_0121, 5'h00);
    reg_wr(8'h04, 32'h1);
    for (i = 0; i < 129; i++) begin
      fill(32'h0001_0121, 5'h00, 8'hFF, 1'b0);
      if (wq.size() < 128) wq.push_back(w);
      if (i == 63 || i == 64) begin
        repeat (12) @(posedge sys_clk);
        check("dma level", {31'h0, dma_req}, {31'h0, i == 64});
      end
    end
    repeat (12) @(posedge sys_clk);
    reg_wr(8'h08, 32'h0);
    reg_rd(8'h08, 32'h1, "full flag");
    check("irq full", {31'h0, irq}, 32'h1);
    reg_wr(8'h04, 32'h2);
    check("irq off", {31'h0, irq}, 32'h0);
    drain(123);
    repeat (3) @(posedge sys_clk);
    check("dma held", {31'h0, dma_req}, 32'h1);
    drain(1);
    repeat (3) @(posedge sys_clk);
    check("dma dropped", {31'h0, dma_req}, 32'h0);
    drain(4);
    reg_rd(8'h08, 32'h3, "both flags");
    check("irq end", {31'h0, irq}, 32'h1);
    complete_run();
  end
endmodule // stream_adc_capture_interface_tb
